// *** shared/pex_pkg.sv ***
// Purpose: shared constants and types for the i2c port expander
// Assumes: sys_clk at 20 MHz, link_clk free running and much faster than scl
// Notes:   variant code is an arbitrary neutral value

package pex_pkg;

	// ------------------------------------------------------------
	// address byte layout
	// ------------------------------------------------------------
	localparam int          ADDR_RW_BIT    = 0;
	localparam int          ADDR_CS_LSB    = 1;
	localparam int          ADDR_CS_MSB    = 3;
	localparam int          ADDR_VAR_LSB   = 4;
	localparam int          ADDR_VAR_MSB   = 7;
	localparam logic [3:0]  VARIANT_CODE   = 4'hA; // arbitrary value
	localparam logic [2:0]  LAST_BIT       = 3'h7;
	localparam logic [2:0]  FIRST_BIT      = 3'h0;
	localparam int          BYTE_MSB       = 7;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0]  PORT_RESET     = 8'hFF;
	localparam logic [7:0]  LATCH_RESET    = 8'hFF;
	localparam logic [7:0]  ALL_ZERO       = 8'h00;

	// ------------------------------------------------------------
	// interrupt filter timing
	// ------------------------------------------------------------
	localparam int          SYS_PERIOD_NS  = 50;
	localparam int          FILTER_NS      = 420;
	localparam int          FILTER_CYC     = (FILTER_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
	localparam logic [3:0]  FILTER_COUNT   = 4'(FILTER_CYC);
	localparam logic [3:0]  COUNT_ZERO     = 4'h0;
	localparam logic [3:0]  COUNT_ONE      = 4'h1;

	// ------------------------------------------------------------
	// link state machine, one-hot
	// ------------------------------------------------------------
	typedef enum logic [6:0] {
		ST_IDLE     = 7'h01,
		ST_ADDR     = 7'h02,
		ST_ADDR_ACK = 7'h04,
		ST_WR_DATA  = 7'h08,
		ST_WR_ACK   = 7'h10,
		ST_RD_DATA  = 7'h20,
		ST_RD_ACK   = 7'h40
	} pex_state_t;

	// sampled bus lines
	typedef struct packed {
		logic scl;
		logic sda;
	} pex_bus_t;

	// events decoded from the bus lines
	typedef struct packed {
		logic scl_rise;
		logic scl_fall;
		logic start;
		logic stop;
	} pex_evt_t;

endpackage

// *** design/pex_expander.sv ***
// Purpose: i2c slave driving a quasi-bidirectional 8-bit port with change interrupt
// Assumes: scl and sda sampled on link_clk, far faster than scl
// Notes:   interrupt filter runs on sys_clk; mismatch level crosses by two flops

`timescale 1ns/10ps

module pex_expander (
	input  wire logic       sys_clk,
	input  wire logic       reset,
	input  wire logic       link_clk,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe_n,
	input  wire logic [2:0] chip_select_pins,
	input  wire logic [7:0] port_in,
	output logic      [7:0] port_out,
	output logic      [7:0] port_oe_n,
	output logic            int_out,
	output logic            int_oe_n
);

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	logic               link_rst_q;
	pex_pkg::pex_bus_t  bus_s_q;
	pex_pkg::pex_bus_t  bus_prev_q;
	pex_pkg::pex_evt_t  evt;
	logic [2:0]         cs_s_q;
	logic [7:0]         pin_s_q;
	pex_pkg::pex_state_t state_q;
	logic [2:0]         bit_cnt_q;
	logic               byte_done_q;
	logic [7:0]         shift_q;
	logic               rw_q;
	logic               master_ack_q;
	logic               sda_low_q;
	logic [7:0]         port_q;
	logic [7:0]         strong_q;
	logic [7:0]         latch_q;
	logic               int_force;
	logic               mismatch_q;
	logic               mis_s_q;
	logic [3:0]         filt_cnt_q;
	logic               int_act_q;
	logic               addr_match;

	// ------------------------------------------------------------
	// link side synchronisers
	// ------------------------------------------------------------

	// reset carried into the link domain
	pex_sync #(
		.W(1)
	) u_pex_sync_rst (
		.clk(link_clk),
		.d  (reset),
		.q  (link_rst_q)
	);

	// bus lines through two flops, scl in the upper bit
	pex_sync #(
		.W(2)
	) u_pex_sync_bus (
		.clk(link_clk),
		.d  ({scl_in, sda_in}),
		.q  (bus_s_q)
	);

	// one more flop on the bus lines for edges
	always_ff @(posedge link_clk) begin
		bus_prev_q <= bus_s_q;
	end

	// chip-select pins through two flops
	pex_sync #(
		.W(3)
	) u_pex_sync_cs (
		.clk(link_clk),
		.d  (chip_select_pins),
		.q  (cs_s_q)
	);

	// port pins through two flops
	pex_sync #(
		.W(8)
	) u_pex_sync_pin (
		.clk(link_clk),
		.d  (port_in),
		.q  (pin_s_q)
	);

	// edge and condition decode
	always_comb begin
		evt.scl_rise = bus_s_q.scl & ~bus_prev_q.scl;
		evt.scl_fall = ~bus_s_q.scl & bus_prev_q.scl;
		evt.start    = bus_s_q.scl & bus_prev_q.scl & bus_prev_q.sda & ~bus_s_q.sda;
		evt.stop     = bus_s_q.scl & bus_prev_q.scl & ~bus_prev_q.sda & bus_s_q.sda;
	end

	// address check against live chip-select levels
	assign addr_match = (shift_q[pex_pkg::ADDR_VAR_MSB:pex_pkg::ADDR_VAR_LSB]
		== pex_pkg::VARIANT_CODE)
		&& (shift_q[pex_pkg::ADDR_CS_MSB:pex_pkg::ADDR_CS_LSB] == cs_s_q);

	// ------------------------------------------------------------
	// transfer state machine
	// ------------------------------------------------------------

	// state, bit counting and sda drive
	always_ff @(posedge link_clk) begin
		if (link_rst_q) begin
			state_q      <= pex_pkg::ST_IDLE;
			bit_cnt_q    <= pex_pkg::FIRST_BIT;
			byte_done_q  <= 1'b0;
			shift_q      <= pex_pkg::ALL_ZERO;
			rw_q         <= 1'b0;
			sda_low_q    <= 1'b0;
		end else if (evt.start) begin
			state_q     <= pex_pkg::ST_ADDR;
			bit_cnt_q   <= pex_pkg::FIRST_BIT;
			byte_done_q <= 1'b0;
			sda_low_q   <= 1'b0;
		end else if (evt.stop) begin
			state_q   <= pex_pkg::ST_IDLE;
			sda_low_q <= 1'b0;
		end else begin
			case (state_q)
			pex_pkg::ST_ADDR, pex_pkg::ST_WR_DATA: begin
				if (evt.scl_rise) begin
					shift_q     <= {shift_q[pex_pkg::BYTE_MSB - 1:0], bus_s_q.sda};
					bit_cnt_q   <= bit_cnt_q + 3'h1;
					byte_done_q <= (bit_cnt_q == pex_pkg::LAST_BIT);
				end else if (evt.scl_fall && byte_done_q) begin
					byte_done_q <= 1'b0;
					if (state_q == pex_pkg::ST_WR_DATA) begin
						sda_low_q <= 1'b1;
						state_q   <= pex_pkg::ST_WR_ACK;
					end else if (addr_match) begin
						rw_q      <= shift_q[pex_pkg::ADDR_RW_BIT];
						sda_low_q <= 1'b1;
						state_q   <= pex_pkg::ST_ADDR_ACK;
					end else begin
						state_q <= pex_pkg::ST_IDLE;
					end
				end
			end
			pex_pkg::ST_ADDR_ACK: begin
				if (evt.scl_fall) begin
					bit_cnt_q <= pex_pkg::FIRST_BIT;
					if (rw_q) begin
						shift_q   <= latch_q;
						sda_low_q <= ~latch_q[pex_pkg::BYTE_MSB];
						state_q   <= pex_pkg::ST_RD_DATA;
					end else begin
						sda_low_q <= 1'b0;
						state_q   <= pex_pkg::ST_WR_DATA;
					end
				end
			end
			pex_pkg::ST_WR_ACK: begin
				if (evt.scl_fall) begin
					sda_low_q <= 1'b0;
					bit_cnt_q <= pex_pkg::FIRST_BIT;
					state_q   <= pex_pkg::ST_WR_DATA;
				end
			end
			pex_pkg::ST_RD_DATA: begin
				if (evt.scl_fall) begin
					bit_cnt_q <= bit_cnt_q + 3'h1;
					shift_q   <= {shift_q[pex_pkg::BYTE_MSB - 1:0], 1'b1};
					if (bit_cnt_q == pex_pkg::LAST_BIT) begin
						sda_low_q <= 1'b0; // release for master ack
						state_q   <= pex_pkg::ST_RD_ACK;
					end else begin
						sda_low_q <= ~shift_q[pex_pkg::BYTE_MSB - 1];
					end
				end
			end
			pex_pkg::ST_RD_ACK: begin
				if (evt.scl_fall) begin
					bit_cnt_q <= pex_pkg::FIRST_BIT;
					if (master_ack_q) begin
						shift_q   <= latch_q;
						sda_low_q <= ~latch_q[pex_pkg::BYTE_MSB];
						state_q   <= pex_pkg::ST_RD_DATA;
					end else begin
						state_q <= pex_pkg::ST_IDLE;
					end
				end
			end
			default: begin
				sda_low_q <= 1'b0;
			end
			endcase
		end
	end

	// master answer to a read byte, taken at the ack clock rise
	always_ff @(posedge link_clk) begin
		if (link_rst_q) begin
			master_ack_q <= 1'b0;
		end else if (state_q == pex_pkg::ST_RD_ACK && evt.scl_rise) begin
			master_ack_q <= ~bus_s_q.sda;
		end
	end

	// ------------------------------------------------------------
	// port output, strong pull-up and read latch
	// ------------------------------------------------------------

	// port register: only complete acknowledged bytes reach it
	always_ff @(posedge link_clk) begin
		if (link_rst_q) begin
			port_q <= pex_pkg::PORT_RESET;
		end else if (state_q == pex_pkg::ST_WR_ACK && evt.scl_rise && !evt.stop) begin
			port_q <= shift_q;
		end
	end

	// strong pull-up pulse for lines written high
	always_ff @(posedge link_clk) begin
		if (link_rst_q) begin
			strong_q <= pex_pkg::ALL_ZERO;
		end else if (evt.scl_fall) begin
			strong_q <= pex_pkg::ALL_ZERO;
		end else if (state_q == pex_pkg::ST_WR_ACK && evt.scl_rise) begin
			strong_q <= shift_q;
		end
	end

	// read latch: loaded at read address ack rise, master-acked read ack rise, or write ack fall
	always_ff @(posedge link_clk) begin
		if (link_rst_q) begin
			latch_q <= pex_pkg::LATCH_RESET;
		end else if (state_q == pex_pkg::ST_ADDR_ACK && rw_q && evt.scl_rise) begin
			latch_q <= pin_s_q;
		end else if (state_q == pex_pkg::ST_RD_ACK && evt.scl_rise && !bus_s_q.sda) begin
			latch_q <= pin_s_q;
		end else if (state_q == pex_pkg::ST_WR_ACK && evt.scl_fall) begin
			latch_q <= pin_s_q;
		end
	end

	// ------------------------------------------------------------
	// interrupt compare
	// ------------------------------------------------------------

	// acknowledge cycles driven by this slave mask the compare
	assign int_force = (state_q == pex_pkg::ST_ADDR_ACK)
		|| (state_q == pex_pkg::ST_WR_ACK);

	// registered mismatch level handed to the system side
	always_ff @(posedge link_clk) begin
		if (link_rst_q) begin
			mismatch_q <= 1'b0;
		end else begin
			mismatch_q <= (|(pin_s_q ^ latch_q)) & ~int_force;
		end
	end

	// ------------------------------------------------------------
	// system side filter
	// ------------------------------------------------------------

	// mismatch level into sys_clk
	pex_sync #(
		.W(1)
	) u_pex_sync_mis (
		.clk(sys_clk),
		.d  (mismatch_q),
		.q  (mis_s_q)
	);

	// low-pass: mismatch must persist before the output asserts
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			filt_cnt_q <= pex_pkg::COUNT_ZERO;
			int_act_q  <= 1'b0;
		end else if (!mis_s_q) begin
			filt_cnt_q <= pex_pkg::COUNT_ZERO;
			int_act_q  <= 1'b0;
		end else if (filt_cnt_q == pex_pkg::FILTER_COUNT) begin
			int_act_q <= 1'b1;
		end else begin
			filt_cnt_q <= filt_cnt_q + pex_pkg::COUNT_ONE;
		end
	end

	// ------------------------------------------------------------
	// pin drivers
	// ------------------------------------------------------------

	// open-drain sda, scl is input only
	assign sda_out  = 1'b0;
	assign sda_oe_n = ~sda_low_q;

	// quasi-bidirectional port: drive low, or high only during the pull-up pulse
	assign port_out  = port_q;
	assign port_oe_n = port_q & ~strong_q;

	// open-drain active-low interrupt
	assign int_out  = 1'b0;
	assign int_oe_n = ~int_act_q;

endmodule

// ------------------------------------------------------------
// two-flop synchroniser
// ------------------------------------------------------------

// carries a level into the domain of clk
module pex_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_q;

	// first stage is read by the second stage only
	always_ff @(posedge clk) begin
		meta_q <= d;
		q      <= meta_q;
	end

endmodule

// *** bench/pex_expander_assertions.sv ***
// Purpose: concurrent checks on the port expander pins
// Assumes: bound to pex_expander, reset synchronous active high
// Notes:   link_clk checks see the raw bus lines, ahead of the synchroniser
`timescale 1ns/10ps
module pex_expander_assertions (
	input wire logic       sys_clk,
	input wire logic       reset,
	input wire logic       link_clk,
	input wire logic       scl_in,
	input wire logic       sda_in,
	input wire logic       sda_out,
	input wire logic       sda_oe_n,
	input wire logic [2:0] chip_select_pins,
	input wire logic [7:0] port_in,
	input wire logic [7:0] port_out,
	input wire logic [7:0] port_oe_n,
	input wire logic       int_out,
	input wire logic       int_oe_n
);
	// ------------------------------------------------------------
	// pin behaviour
	// ------------------------------------------------------------
	reset_vals_a: assert property (@(posedge sys_clk) reset[*4] |->
		sda_oe_n && int_oe_n && port_out == 8'hFF && port_oe_n == 8'hFF)
		else $error("outputs not at reset values");
	sda_open_a: assert property (@(posedge link_clk) disable iff (reset) !sda_out)
		else $error("sda driven high");
	int_open_a: assert property (@(posedge sys_clk) disable iff (reset) !int_out)
		else $error("interrupt driven high");
	port_upd_a: assert property (@(posedge link_clk) disable iff (reset)
		$changed(port_out) |-> scl_in) else $error("port updated while scl low");
	ack_start_a: assert property (@(posedge link_clk) disable iff (reset)
		$fell(sda_oe_n) |-> !scl_in) else $error("sda pulled while scl high");
	ack_hold_a: assert property (@(posedge link_clk) disable iff (reset)
		$fell(sda_oe_n) |-> (!sda_oe_n)[*8]) else $error("sda drive too short");
	stop_rel_a: assert property (@(posedge link_clk) disable iff (reset)
		scl_in && $past(scl_in) && $rose(sda_in) |=> sda_oe_n[*8])
		else $error("sda held after stop");
	pullup_off_a: assert property (@(posedge link_clk) disable iff (reset)
		$fell(scl_in) |-> ##6 port_oe_n == port_out) else $error("pull-up left on");
	drive_low_a: assert property (@(posedge link_clk) disable iff (reset)
		(~port_out & port_oe_n) == 8'h00) else $error("low port bit not driven");
	int_filt_a: assert property (@(posedge sys_clk) disable iff (reset)
		$fell(int_oe_n) |-> port_in == $past(port_in, 8)) else $error("interrupt unfiltered");
	// main scenarios reached
	ack_seen_c: cover property (@(posedge link_clk) $fell(sda_oe_n));
	int_seen_c: cover property (@(posedge sys_clk) $fell(int_oe_n));
	port_upd_c: cover property (@(posedge link_clk) $changed(port_out));
endmodule
bind pex_expander pex_expander_assertions u_pex_expander_assertions (.sys_clk(sys_clk),
	.reset(reset), .link_clk(link_clk), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
	.sda_oe_n(sda_oe_n), .chip_select_pins(chip_select_pins), .port_in(port_in),
	.port_out(port_out), .port_oe_n(port_oe_n), .int_out(int_out), .int_oe_n(int_oe_n));

// *** bench/pex_i2c_master.sv ***
// Purpose: behavioural bus master for the port expander bench
// Assumes: one bit takes four sys_clk cycles, two low and two high
// Notes:   sda_drv high means released, the pull-up gives the level
`timescale 1ns/10ps
module pex_i2c_master (
	input  wire logic sys_clk,
	output logic      scl,
	output logic      sda_drv,
	input  wire logic sda_wire
);
	// ------------------------------------------------------------
	// bus conditions and bits
	// ------------------------------------------------------------
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	// start or repeated start
	task automatic start;
		@(posedge sys_clk) sda_drv <= 1'b1;
		@(posedge sys_clk) scl <= 1'b1;
		@(posedge sys_clk) sda_drv <= 1'b0;
		@(posedge sys_clk) scl <= 1'b0;
	endtask
	// stop, bus left idle high
	task automatic stop;
		@(posedge sys_clk) sda_drv <= 1'b0;
		@(posedge sys_clk) scl <= 1'b1;
		@(posedge sys_clk) sda_drv <= 1'b1;
	endtask
	// one clock, sda changed only while scl low
	task automatic bit_io(input logic b, output logic r);
		@(posedge sys_clk) sda_drv <= b;
		@(posedge sys_clk) scl <= 1'b1;
		@(posedge sys_clk) r = sda_wire;
		@(posedge sys_clk) scl <= 1'b0;
	endtask
	// byte plus acknowledge clock
	task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic ar);
		for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
		bit_io(a, ar);
	endtask
endmodule

// *** bench/tb_pex_expander.sv ***
// Purpose: self-checking bench for the port expander
// Assumes: port lines weakly high unless the bench drives them
// Notes:   scl is never stretched by the device, only by the bench
`timescale 1ns/10ps
module tb_pex_expander;
	logic       sys_clk, reset, link_clk, scl, sda_drv, sda_w, sda_out, sda_oe_n;
	logic       int_out, int_oe_n, ar;
	logic [2:0] cs_pins;
	logic [7:0] ext, port_w, port_out, port_oe_n, q;
	int         error_cnt, n_tests, int_lows;
	localparam logic [3:0] VC = pex_pkg::VARIANT_CODE;
	// ------------------------------------------------------------
	// clocks, wires, instances
	// ------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	initial begin
		link_clk = 1'b0;
		#1.7;
		forever #3 link_clk = ~link_clk;
	end
	// open-drain sda and quasi-bidirectional port lines
	assign sda_w = sda_drv & (sda_oe_n | sda_out);
	assign port_w = (port_oe_n & ext) | (~port_oe_n & port_out);
	pex_expander u_pex_expander (.sys_clk(sys_clk), .reset(reset), .link_clk(link_clk),
		.scl_in(scl), .sda_in(sda_w), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
		.chip_select_pins(cs_pins), .port_in(port_w), .port_out(port_out),
		.port_oe_n(port_oe_n), .int_out(int_out), .int_oe_n(int_oe_n));
	pex_i2c_master u_pex_i2c_master (.sys_clk(sys_clk), .scl(scl), .sda_drv(sda_drv),
		.sda_wire(sda_w));
	// counts cycles with the interrupt low
	always @(posedge sys_clk) if (int_oe_n === 1'b0) int_lows <= int_lows + 1;
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic check(input string nm, input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic set_ext(input logic [7:0] v);
		@(posedge sys_clk) ext <= v;
	endtask
	task automatic open_dev(input logic rw);
		u_pex_i2c_master.start();
		u_pex_i2c_master.xfer({VC, cs_pins, rw}, 1'b1, q, ar);
		check("addr ack", 8'(ar), 8'h00);
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset;
		check("port_out", port_out, 8'hFF);
		check("port_oe_n", port_oe_n, 8'hFF);
		check("sda int", 8'({sda_oe_n, int_oe_n}), 8'h03);
		$display("test reset done");
	endtask
	task automatic t_write;
		int n;
		n = int_lows;
		open_dev(1'b0);
		u_pex_i2c_master.xfer(8'h5A, 1'b1, q, ar);
		check("wr ack", 8'(ar), 8'h00);
		check("port", port_out, 8'h5A);
		u_pex_i2c_master.xfer(8'h0F, 1'b1, q, ar);
		check("wr ack2", 8'(ar), 8'h00);
		check("port2", port_out, 8'h0F);
		u_pex_i2c_master.stop();
		wait_cyc(4);
		check("port stop", port_out, 8'h0F);
		check("int lows", 8'(int_lows - n), 8'h00);
		open_dev(1'b0);
		for (int i = 0; i < 4; i++) u_pex_i2c_master.bit_io(1'b0, ar);
		u_pex_i2c_master.stop();
		check("partial", port_out, 8'h0F);
		open_dev(1'b0);
		u_pex_i2c_master.xfer(8'hFF, 1'b1, q, ar);
		u_pex_i2c_master.stop();
		$display("test write done");
	endtask
	task automatic t_addr;
		logic [6:0] addr7;
		addr7 = {VC, 3'h2};
		u_pex_i2c_master.start();
		u_pex_i2c_master.xfer({VC, 3'h2, 1'b0}, 1'b1, q, ar);
		check("cs nack", 8'(ar), 8'h01);
		u_pex_i2c_master.stop();
		u_pex_i2c_master.start();
		for (int i = 7; i >= 1; i--) u_pex_i2c_master.bit_io(addr7[i - 1], ar);
		@(posedge sys_clk) cs_pins <= 3'h2;
		u_pex_i2c_master.bit_io(1'b0, ar);
		u_pex_i2c_master.bit_io(1'b1, ar);
		check("late cs ack", 8'(ar), 8'h00);
		u_pex_i2c_master.stop();
		@(posedge sys_clk) cs_pins <= 3'h5;
		$display("test address done");
	endtask
	task automatic t_read;
		set_ext(8'hC3);
		wait_cyc(20);
		check("int set", 8'(int_oe_n), 8'h00);
		open_dev(1'b1);
		wait_cyc(4);
		check("int clr", 8'(int_oe_n), 8'h01);
		set_ext(8'h3C);
		u_pex_i2c_master.xfer(8'hFF, 1'b0, q, ar);
		check("rd1", q, 8'hC3);
		set_ext(8'h00);
		u_pex_i2c_master.xfer(8'hFF, 1'b1, q, ar);
		check("rd2", q, 8'h3C);
		u_pex_i2c_master.xfer(8'hFF, 1'b1, q, ar);
		check("rd3", q, 8'hFF);
		u_pex_i2c_master.stop();
		wait_cyc(20);
		check("no recap", 8'(int_oe_n), 8'h00);
		$display("test read done");
	endtask
	task automatic t_int;
		int n;
		set_ext(8'h3C);
		wait_cyc(20);
		check("int back", 8'(int_oe_n), 8'h01);
		n = int_lows;
		set_ext(8'h3D);
		wait_cyc(4);
		set_ext(8'h3C);
		wait_cyc(20);
		check("glitch", 8'(int_lows - n), 8'h00);
		set_ext(8'h3E);
		wait_cyc(20);
		check("int chg", 8'(int_oe_n), 8'h00);
		open_dev(1'b1);
		u_pex_i2c_master.xfer(8'hFF, 1'b1, q, ar);
		check("rd", q, 8'h3E);
		u_pex_i2c_master.stop();
		wait_cyc(5);
		check("int read", 8'(int_oe_n), 8'h01);
		$display("test interrupt done");
	endtask
	// ------------------------------------------------------------
	// main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		reset = 1'b1;
		ext = 8'hFF;
		cs_pins = 3'h5;
		error_cnt = 0;
		n_tests = 0;
		repeat (12) @(posedge sys_clk);
		reset <= 1'b0;
		wait_cyc(4);
		t_reset();
		t_write();
		t_addr();
		t_read();
		t_int();
		give_verdict();
	end
	initial begin
		repeat (20000) @(posedge sys_clk);
		error_cnt++;
		give_verdict();
	end
endmodule
